// ---- common/epg_cfg.svh ----
// Constants of the program guard: opcodes, field widths, timing.
// Assumes inclusion by bare name from the package and design files.
`ifndef EPG_CFG_SVH
`define EPG_CFG_SVH

`define EPG_OP_SPECIAL    2'h0
`define EPG_OP_WRITE      2'h1
`define EPG_OP_ERASE      2'h3
`define EPG_SUB_FILL      2'h1
`define EPG_SUB_CLEAR     2'h2
`define EPG_START_BITS    1
`define EPG_OP_BITS       2
`define EPG_SUB_BITS      2
`define EPG_ADDR_X8       9
`define EPG_ADDR_X16      8
`define EPG_DATA_X8       8
`define EPG_DATA_X16      16
`define EPG_BYTE_ONES     8'hFF
`define EPG_WORD_ONES     16'hFFFF
`define EPG_CNT_W         6
`define EPG_PROG_TIME_NS  20000
`define EPG_SYS_PERIOD_NS 5

`endif

// ---- common/epg_pkg.sv ----
// Types shared by the program guard modules.
// Assumes epg_cfg.svh is on the include path.
`include "epg_cfg.svh"

package epg_pkg;
    typedef enum logic [1:0] {
        EPG_IDLE,
        EPG_WALK,
        EPG_WAIT
    } epg_state_t;

    typedef enum logic [2:0] {
        EPG_K_NONE,
        EPG_K_WRITE,
        EPG_K_ERASE,
        EPG_K_FILL,
        EPG_K_CLEAR
    } epg_kind_t;
endpackage

// ---- src/epg_sync.sv ----
// Two-stage level synchroniser, one chain per bit.
// Assumes inputs are quasi-static levels from another domain.
`timescale 1ns/100ps

module epg_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta_reg;
        logic sync_reg;
        always_ff @(posedge clk) begin
            if (!resetn) begin
                meta_reg <= 1'b0;
                sync_reg <= 1'b0;
            end else begin
                meta_reg <= async_in[i];
                sync_reg <= meta_reg;
            end
        end
        assign sync_out[i] = sync_reg;
    end
endmodule

// ---- src/epg_array.sv ----
// Byte-wide storage array with one write and one registered read port.
// Assumes a single clock; content survives reset like the real cells.
`timescale 1ns/100ps
`include "epg_cfg.svh"

module epg_array
    import epg_pkg::*;
#(
    parameter int ADDR_W = `EPG_ADDR_X8
) (
    // Clock
    input  wire logic              clk,
    // Write port
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [7:0]        wr_data,
    // Read port
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [7:0]        rd_data
);
    logic [7:0] mem [0:(1<<ADDR_W)-1];

    // Delivered blank
    initial begin
        for (int i = 0; i < (1<<ADDR_W); i++) begin
            mem[i] = `EPG_BYTE_ONES;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule

// ---- src/epg_guard.sv ----
// Programming-cycle guard of a three-wire serial memory slave.
// Assumes ser_clk comes from the host and stops while select is low.
//
// Summary of operation
// - Fill-all programs the one supplied byte or word into every address.
// - Fill-all address carries don't-care low bits; they are never decoded.
// - While programming, select high gives busy low on output; bus ignored.
// - After programming finishes, output shows high while select is high.
// - Ready/busy shown after write, erase, fill-all and clear-all instructions.
// - Ready high held until a new start bit or select goes low.
// - Count clock pulses from the start bit until select falls.
// - x8 write executes only with exactly 20 pulses, else discarded.
// - x16 write executes only with exactly 27 pulses, else discarded.
// - Exact count checked for write, erase, clear-all, fill-all; fill-all shares write's count, clear-all erase's.
// - Array content starts as all ones.
// - Clear-all sets every bit to one, with self-timed ready/busy cycle.
// - Fill-all is start one, opcode 00, address beginning 01, then data.
`timescale 1ns/100ps
`include "epg_cfg.svh"

module epg_guard
    import epg_pkg::*;
#(
    parameter int A8          = `EPG_ADDR_X8,
    parameter int A16         = `EPG_ADDR_X16,
    parameter int D8          = `EPG_DATA_X8,
    parameter int D16         = `EPG_DATA_X16,
    parameter int PROG_CYCLES = `EPG_PROG_TIME_NS / `EPG_SYS_PERIOD_NS
) (
    // System clock and reset
    input  wire logic          sys_clk,
    input  wire logic          resetn,
    // Serial link from the host
    input  wire logic          ser_clk,
    input  wire logic          sel,
    input  wire logic          sdi,
    input  wire logic          org_x16,
    // Serial output pin
    output logic               so_out,
    output logic               so_oe,
    // Status
    output logic               busy,
    output logic               cmd_done,
    output logic               cmd_reject,
    // Array inspection port
    input  wire logic [A8-1:0] peek_addr,
    output logic      [7:0]    peek_data
);
    localparam int OPB  = `EPG_OP_BITS;
    localparam int SUBB = `EPG_SUB_BITS;
    localparam int CW   = `EPG_CNT_W;
    localparam int L8E  = OPB + A8;
    localparam int L8W  = L8E + D8;
    localparam int L16E = OPB + A16;
    localparam int L16W = L16E + D16;
    localparam int SH_W = (L8W > L16W) ? L8W : L16W;
    localparam logic [CW-1:0] REQ8E  = CW'(`EPG_START_BITS + L8E);
    localparam logic [CW-1:0] REQ8W  = CW'(`EPG_START_BITS + L8W);
    localparam logic [CW-1:0] REQ16E = CW'(`EPG_START_BITS + L16E);
    localparam logic [CW-1:0] REQ16W = CW'(`EPG_START_BITS + L16W);
    localparam logic [CW-1:0] CNT_MAX = '1;
    localparam int TW = $clog2(PROG_CYCLES + 1);
    localparam logic [TW-1:0] TIMER_END = TW'(PROG_CYCLES - 1);

    // Byte array only serves byte/word organisations
    if (D8 != 8 || D16 != 16 || A8 != A16 + 1 || PROG_CYCLES < 1
        || SH_W + 1 >= (1 << CW)) begin : g_bad_cfg
        $error("epg_guard: unsupported parameter set");
    end

    // Link domain
    logic            link_clr_reg;
    logic            started_reg;
    logic [CW-1:0]   cnt_reg;
    logic [SH_W-1:0] sh_reg;

    // Cleared by the frame's own end, taken over by the system side
    always_ff @(posedge ser_clk or posedge link_clr_reg) begin
        if (link_clr_reg) begin
            started_reg <= 1'b0;
            cnt_reg     <= '0;
            sh_reg      <= '0;
        end else if (sel) begin
            if (!started_reg) begin
                if (sdi) begin
                    started_reg <= 1'b1;
                    cnt_reg     <= CW'(`EPG_START_BITS);
                end
            end else begin
                // Saturate so a long burst never wraps to a match
                if (cnt_reg != CNT_MAX) begin
                    cnt_reg <= cnt_reg + CW'(1);
                end
                sh_reg <= {sh_reg[SH_W-2:0], sdi};
            end
        end
    end

    // Pin and cross-domain levels
    logic [2:0] sync_out;
    logic       sel_s;
    logic       org_s;
    logic       start_s;

    epg_sync #(.WIDTH(3)) u_sync (
        .clk      (sys_clk),
        .resetn   (resetn),
        .async_in ({started_reg, org_x16, sel}),
        .sync_out (sync_out)
    );

    assign sel_s   = sync_out[0];
    assign org_s   = sync_out[1];
    assign start_s = sync_out[2];

    logic sel_prev_reg;
    logic start_prev_reg;
    logic sel_fall;
    logic start_rise;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sel_prev_reg   <= 1'b0;
            start_prev_reg <= 1'b0;
        end else begin
            sel_prev_reg   <= sel_s;
            start_prev_reg <= start_s;
        end
    end

    assign sel_fall   = sel_prev_reg & ~sel_s;
    assign start_rise = start_s & ~start_prev_reg;

    // Link words are read in the fall cycle, then the link is cleared
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            link_clr_reg <= 1'b1;
        end else begin
            link_clr_reg <= ~(sel_s | sel_prev_reg);
        end
    end

    // Decode, only consumed on the select fall
    epg_kind_t   kind;
    logic [A8-1:0] first_addr;
    logic [A8-1:0] last_addr;
    logic [15:0]   word;
    logic [1:0]    op;
    logic [1:0]    sub;

    always_comb begin
        kind       = EPG_K_NONE;
        first_addr = '0;
        last_addr  = '1;
        word       = `EPG_WORD_ONES;
        op         = '0;
        sub        = '0;
        if (!org_s) begin
            if (cnt_reg == REQ8W) begin
                op  = sh_reg[L8W-1 -: OPB];
                sub = sh_reg[L8W-OPB-1 -: SUBB];
                word[7:0] = sh_reg[D8-1:0];
                if (op == `EPG_OP_WRITE) begin
                    kind       = EPG_K_WRITE;
                    first_addr = sh_reg[D8 +: A8];
                    last_addr  = sh_reg[D8 +: A8];
                end else if (op == `EPG_OP_SPECIAL && sub == `EPG_SUB_FILL) begin
                    kind = EPG_K_FILL;
                end
            end else if (cnt_reg == REQ8E) begin
                op  = sh_reg[L8E-1 -: OPB];
                sub = sh_reg[L8E-OPB-1 -: SUBB];
                if (op == `EPG_OP_ERASE) begin
                    kind       = EPG_K_ERASE;
                    first_addr = sh_reg[A8-1:0];
                    last_addr  = sh_reg[A8-1:0];
                end else if (op == `EPG_OP_SPECIAL && sub == `EPG_SUB_CLEAR) begin
                    kind = EPG_K_CLEAR;
                end
            end
        end else begin
            if (cnt_reg == REQ16W) begin
                op   = sh_reg[L16W-1 -: OPB];
                sub  = sh_reg[L16W-OPB-1 -: SUBB];
                word = sh_reg[D16-1:0];
                if (op == `EPG_OP_WRITE) begin
                    kind       = EPG_K_WRITE;
                    first_addr = {sh_reg[D16 +: A16], 1'b0};
                    last_addr  = {sh_reg[D16 +: A16], 1'b1};
                end else if (op == `EPG_OP_SPECIAL && sub == `EPG_SUB_FILL) begin
                    kind = EPG_K_FILL;
                end
            end else if (cnt_reg == REQ16E) begin
                op  = sh_reg[L16E-1 -: OPB];
                sub = sh_reg[L16E-OPB-1 -: SUBB];
                if (op == `EPG_OP_ERASE) begin
                    kind       = EPG_K_ERASE;
                    first_addr = {sh_reg[A16-1:0], 1'b0};
                    last_addr  = {sh_reg[A16-1:0], 1'b1};
                end else if (op == `EPG_OP_SPECIAL && sub == `EPG_SUB_CLEAR) begin
                    kind = EPG_K_CLEAR;
                end
            end
        end
        // Fill and clear ignore the don't-care address bits entirely
        if (kind == EPG_K_FILL || kind == EPG_K_CLEAR) begin
            first_addr = '0;
            last_addr  = '1;
        end
        if (kind == EPG_K_ERASE || kind == EPG_K_CLEAR) begin
            word = `EPG_WORD_ONES;
        end
    end

    // Programming engine
    epg_state_t      state_reg;
    logic [A8-1:0]   ptr_reg;
    logic [A8-1:0]   last_reg;
    logic [15:0]     word_reg;
    logic            x16_reg;
    logic [TW-1:0]   timer_reg;
    logic            idle;
    logic            exec;
    logic            finish;

    assign idle   = (state_reg == EPG_IDLE);
    // Frames landing in a running cycle are dropped whole
    assign exec   = sel_fall && idle && kind != EPG_K_NONE;
    assign finish = (state_reg == EPG_WAIT) && timer_reg == TIMER_END;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_reg <= EPG_IDLE;
        end else begin
            case (state_reg)
                EPG_IDLE: begin
                    if (exec) begin
                        state_reg <= EPG_WALK;
                    end
                end
                EPG_WALK: begin
                    if (ptr_reg == last_reg) begin
                        state_reg <= EPG_WAIT;
                    end
                end
                EPG_WAIT: begin
                    if (finish) begin
                        state_reg <= EPG_IDLE;
                    end
                end
                default: begin
                    state_reg <= EPG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ptr_reg  <= '0;
            last_reg <= '0;
            word_reg <= `EPG_WORD_ONES;
            x16_reg  <= 1'b0;
        end else if (exec) begin
            ptr_reg  <= first_addr;
            last_reg <= last_addr;
            word_reg <= word;
            x16_reg  <= org_s;
        end else if (state_reg == EPG_WALK && ptr_reg != last_reg) begin
            ptr_reg <= ptr_reg + A8'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            timer_reg <= '0;
        end else if (state_reg == EPG_WAIT) begin
            timer_reg <= timer_reg + TW'(1);
        end else begin
            timer_reg <= '0;
        end
    end

    // Word organisation: even byte low half, odd byte high half
    logic [7:0] wr_byte;
    assign wr_byte = (x16_reg && ptr_reg[0]) ? word_reg[15:8] : word_reg[7:0];

    epg_array #(.ADDR_W(A8)) u_array (
        .clk     (sys_clk),
        .wr_en   (state_reg == EPG_WALK),
        .wr_addr (ptr_reg),
        .wr_data (wr_byte),
        .rd_addr (peek_addr),
        .rd_data (peek_data)
    );

    // Ready/busy reporting
    logic status_reg;
    logic shown_reg;
    logic status_end;

    assign status_end = status_reg && idle && !exec
                        && (start_rise || (!sel_s && shown_reg));

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            status_reg <= 1'b0;
        end else if (exec) begin
            status_reg <= 1'b1;
        end else if (status_end) begin
            status_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            shown_reg <= 1'b0;
        end else if (exec || status_end) begin
            shown_reg <= 1'b0;
        end else if (status_reg && idle && sel_s) begin
            shown_reg <= 1'b1;
        end
    end

    // Pin driven only while selected and a cycle is being reported
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            so_oe  <= 1'b0;
            so_out <= 1'b0;
        end else begin
            so_oe  <= sel_s && status_reg && !status_end;
            so_out <= sel_s && status_reg && !status_end && idle;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            busy       <= 1'b0;
            cmd_done   <= 1'b0;
            cmd_reject <= 1'b0;
        end else begin
            busy       <= !idle || exec;
            cmd_done   <= finish;
            cmd_reject <= sel_fall && start_prev_reg && !exec;
        end
    end
endmodule

// ---- bench/epg_guard_asserts.sv ----
// Checker for the program guard, watching its top-level ports.
// Assumes binding into epg_guard; only the sys_clk domain is watched.
`timescale 1ns/100ps

module epg_guard_asserts #(
    parameter int PROG_CYCLES = 4000
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Link select
    input wire logic sel,
    // Status
    input wire logic so_out,
    input wire logic so_oe,
    input wire logic busy,
    input wire logic cmd_done,
    input wire logic cmd_reject
);
    int busy_cnt;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // Length of the current programming cycle
    always_ff @(posedge sys_clk) begin
        if (!resetn || !busy) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_cnt + 1;
        end
    end

    property p_done_pulse;
        cmd_done |=> !cmd_done ##1 !busy;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse ending busy");

    property p_rej_pulse;
        cmd_reject |-> !$rose(busy) ##1 !cmd_reject;
    endproperty
    a_rej_pulse: assert property (p_rej_pulse) else $error("reject started a cycle");

    property p_busy_low;
        busy && so_oe && !cmd_done && !$past(cmd_done) |-> !so_out;
    endproperty
    a_busy_low: assert property (p_busy_low) else $error("output not low while busy");

    property p_ready_high;
        !busy && !$past(busy) && so_oe |-> so_out;
    endproperty
    a_ready_high: assert property (p_ready_high) else $error("output not high when ready");

    property p_oe_sel;
        !sel [*6] |-> !so_oe;
    endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("output driven while deselected");

    property p_busy_after_sel;
        $rose(busy) |-> !sel;
    endproperty
    a_busy_after_sel: assert property (p_busy_after_sel) else $error("cycle began with select high");

    property p_prog_min;
        cmd_done |-> busy_cnt >= PROG_CYCLES - 1;
    endproperty
    a_prog_min: assert property (p_prog_min) else $error("programming cycle too short");

    property p_prog_max;
        busy_cnt <= PROG_CYCLES + 600;
    endproperty
    a_prog_max: assert property (p_prog_max) else $error("programming cycle too long");

    property p_busy_run;
        $rose(busy) |-> busy [*8];
    endproperty
    a_busy_run: assert property (p_busy_run) else $error("busy dropped early");
endmodule

bind epg_guard epg_guard_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .sys_clk(sys_clk), .resetn(resetn), .sel(sel), .so_out(so_out), .so_oe(so_oe),
    .busy(busy), .cmd_done(cmd_done), .cmd_reject(cmd_reject));

// ---- bench/epg_host.sv ----
// Host serial master model driving select, link clock and data.
// Assumes the bench calls its tasks; link clock idles low between frames.
`timescale 1ns/100ps

module epg_host (
    // Serial link
    output logic ser_clk,
    output logic sel,
    output logic sdi
);
    logic bq[$];

    initial begin
        ser_clk = 1'b0;
        sel = 1'b0;
        sdi = 1'b0;
    end

    // Appends n low bits of v, most significant first
    task automatic add(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            bq.push_back(v[i]);
        end
    endtask

    // One frame at 80 ns per bit; extra pulses mimic clock glitches
    task automatic frame(input int extra);
        sel = 1'b1;
        #40;
        foreach (bq[i]) begin
            sdi = bq[i];
            #40 ser_clk = 1'b1;
            #40 ser_clk = 1'b0;
        end
        repeat (extra) begin
            #40 ser_clk = 1'b1;
            #40 ser_clk = 1'b0;
        end
        sel = 1'b0;
        sdi = ~sdi;
        bq.delete();
        #40;
    endtask

    // Select alone, for status polling
    task automatic hold(input logic on);
        sel = on;
    endtask
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the program guard with a host model.
// Assumes epg_guard with a short programming time of 40 cycles.
`timescale 1ns/100ps

module tb;
    import epg_pkg::*;
    logic       sys_clk, resetn, org_x16, ser_clk, sel, sdi;
    logic       so_out, so_oe, busy, cmd_done, cmd_reject;
    int         done_cnt, rej_cnt, done_base, rej_base;
    logic [8:0] peek_addr;
    logic [7:0] peek_data;
    int         error_cnt, n_compared;

    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;

    epg_host h (.ser_clk(ser_clk), .sel(sel), .sdi(sdi));
    epg_guard #(.PROG_CYCLES(40)) uut (.sys_clk(sys_clk), .resetn(resetn), .ser_clk(ser_clk),
        .sel(sel), .sdi(sdi), .org_x16(org_x16), .so_out(so_out), .so_oe(so_oe), .busy(busy),
        .cmd_done(cmd_done), .cmd_reject(cmd_reject), .peek_addr(peek_addr), .peek_data(peek_data));

    // Pulses are short, so count them while the host is busy
    always @(posedge sys_clk) begin
        if (cmd_done) done_cnt <= done_cnt + 1;
        if (cmd_reject) rej_cnt <= rej_cnt + 1;
    end

    task automatic close_out();
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic peek(input logic [8:0] a, input logic [7:0] exp);
        @(posedge sys_clk) peek_addr <= a;
        repeat (2) @(posedge sys_clk);
        #1 chk(peek_data, exp);
    endtask

    task automatic wait_on(input logic rej);
        int i;
        for (i = 0; i < 4000; i++) begin
            if (rej ? (rej_cnt != rej_base) : (done_cnt != done_base)) break;
            @(posedge sys_clk);
        end
        if (i == 4000) begin
            error_cnt++;
            $display("Error at %0t: wait timed out", $time);
            close_out();
        end
    endtask

    task automatic cmd(input logic [2:0] hd, input logic [15:0] a, input int na, input logic [15:0] d, input int nd);
        h.add({13'h0000, hd}, 3);
        h.add(a, na);
        h.add(d, nd);
    endtask

    // Sends the queued frame; accepted ones are polled for busy then ready
    task automatic go(input int extra, input logic ok);
        done_base = done_cnt;
        rej_base = rej_cnt;
        h.frame(extra);
        if (ok) begin
            h.hold(1'b1);
            repeat (6) @(posedge sys_clk);
            #1 chk({6'h00, so_oe, so_out}, 8'h02);
            wait_on(1'b0);
            repeat (4) @(posedge sys_clk);
            #1 chk({6'h00, so_oe, so_out}, 8'h03);
            h.hold(1'b0);
        end else begin
            wait_on(1'b1);
            chk({7'h00, (done_cnt != done_base)}, 8'h00);
        end
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic t_deliv();
        peek(9'h000, 8'hFF);
        peek(9'h1FF, 8'hFF);
    endtask

    task automatic t_write8();
        cmd(3'h5, 16'h0005, 9, 16'h00A5, 8);
        go(0, 1'b1);
        peek(9'h005, 8'hA5);
        cmd(3'h5, 16'h0005, 9, 16'h003C, 8);
        go(1, 1'b0);
        peek(9'h005, 8'hA5);
        cmd(3'h5, 16'h0005, 9, 16'h003C, 7);
        go(0, 1'b0);
        peek(9'h005, 8'hA5);
    endtask

    task automatic t_x16();
        @(posedge sys_clk) org_x16 <= 1'b1;
        repeat (4) @(posedge sys_clk);
        cmd(3'h5, 16'h0003, 8, 16'h1234, 16);
        go(0, 1'b1);
        peek(9'h006, 8'h34);
        peek(9'h007, 8'h12);
        cmd(3'h5, 16'h0003, 8, 16'h5678, 15);
        go(0, 1'b0);
        peek(9'h006, 8'h34);
        cmd(3'h4, 16'h0057, 8, 16'hBEEF, 16);
        go(0, 1'b1);
        peek(9'h000, 8'hEF);
        peek(9'h1FF, 8'hBE);
        cmd(3'h7, 16'h0003, 8, 16'h0000, 0);
        go(0, 1'b1);
        peek(9'h007, 8'hFF);
        peek(9'h005, 8'hBE);
        @(posedge sys_clk) org_x16 <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic t_erase_fill();
        cmd(3'h7, 16'h0005, 9, 16'h0000, 0);
        go(0, 1'b1);
        peek(9'h005, 8'hFF);
        cmd(3'h4, 16'h00D3, 9, 16'h005A, 8);
        go(0, 1'b1);
        peek(9'h000, 8'h5A);
        peek(9'h0D3, 8'h5A);
        peek(9'h1FF, 8'h5A);
    endtask

    task automatic t_clear();
        cmd(3'h4, 16'h0100, 9, 16'h0000, 0);
        h.frame(0);
        cmd(3'h5, 16'h0005, 9, 16'h003C, 8);
        go(0, 1'b0);
        wait_on(1'b0);
        repeat (4) @(posedge sys_clk);
        peek(9'h000, 8'hFF);
        peek(9'h005, 8'hFF);
        peek(9'h1FF, 8'hFF);
    endtask

    initial begin
        resetn = 1'b0;
        org_x16 = 1'b0;
        peek_addr = 9'h000;
        error_cnt = 0;
        n_compared = 0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_deliv();
        t_write8();
        t_x16();
        t_erase_fill();
        t_clear();
        close_out();
    end
endmodule
